//--- common/dcd_pkg.sv
// Constants, field positions and command codes for the DDR3 command decoder
package dcd_pkg;
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 14;
  localparam int DQ_W = 16;
  localparam int LANE_W = 8;
  localparam int BEAT_W = 3;
  localparam int CORE_W = 128;
  localparam int BYTES_W = 16;
  localparam int SYNC_W = 41;
  localparam int AP_BIT = 10;
  localparam int CHOP_BIT = 12;
  localparam int BT_BIT = 3;
  localparam logic [BEAT_W-1:0] LAST_FULL = 3'h7;
  localparam logic [BEAT_W-1:0] LAST_CHOP = 3'h3;
  localparam logic [BANK_W-1:0] MR0_BANK = 3'h0;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [2:0] ENC_ACT = 3'h3;
  localparam logic [2:0] ENC_PRE = 3'h2;
  localparam logic [2:0] ENC_WR = 3'h4;
  localparam logic [2:0] ENC_RD = 3'h5;
  localparam logic [2:0] ENC_MRS = 3'h0;
  localparam logic [2:0] ENC_REF = 3'h1;
  localparam logic [2:0] ENC_ZQ = 3'h6;
  localparam logic [2:0] ENC_NOP = 3'h7;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_ACT = 4'h1,
    CMD_PRE = 4'h2,
    CMD_PREA = 4'h3,
    CMD_WR = 4'h4,
    CMD_RD = 4'h5,
    CMD_MRS = 4'h6,
    CMD_REF = 4'h7,
    CMD_SRE = 4'h8,
    CMD_SRX = 4'h9,
    CMD_PDE = 4'hA,
    CMD_PDX = 4'hB,
    CMD_ZQCL = 4'hC,
    CMD_ZQCS = 4'hD,
    CMD_NOP = 4'hE,
    CMD_DES = 4'hF
  } dcd_cmd_e;
endpackage

//--- design/dcd_pin_sync.sv
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
`default_nettype none
module dcd_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stable_q;
  logic [WIDTH-1:0] stable_d;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_comb
      begin
        meta_d[i] = asyncIn[i];
        stable_d[i] = meta_q[i];
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      stable_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      stable_q <= stable_d;
    end
  end

  assign syncOut = stable_q;
endmodule
`default_nettype wire

//--- design/dcd_command_decoder.sv
// DDR3 command decoder: pin sampling, bank state, low-power modes and burst engine
// Notes on behaviour
// - Activate opens given row in idle bank
// - RAS low CAS high: WE picks act/precharge
// - Write decode; auto-close flag adds precharge
// - Read decode; auto-close flag adds precharge
// - On-the-fly chop line: low four, high eight
// - Mode set only all idle, all low
// - Power-down entry on gate fall with nop, all banks idle
// - Refresh gate high; falling gate self-refresh
// - Gate rising with nop exits low power
// - Byte masks high block their lane independently
// - Eight independent banks each hold open row
// - One core word spans burst, two beats/clock
// - Bursts of eight or chopped four, ordered
// - Captured address is burst starting column
`timescale 1ns/100ps
`default_nettype none
module dcd_command_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic ckPin,
  input wire logic ckeIn,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [dcd_pkg::BANK_W-1:0] bankSelect,
  input wire logic [dcd_pkg::ADDR_W-1:0] rowColumnLines,
  input wire logic lowerByteMask,
  input wire logic upperByteMask,
  input wire logic [dcd_pkg::DQ_W-1:0] dqIn,
  output logic cmdValid,
  output dcd_pkg::dcd_cmd_e cmdCode,
  output logic [dcd_pkg::BANK_W-1:0] cmdBank,
  output logic [dcd_pkg::ADDR_W-1:0] cmdAddr,
  output logic cmdAutoPrecharge,
  output logic cmdChopped,
  output logic zqLong,
  output logic [dcd_pkg::NUM_BANKS-1:0] bankActive,
  output logic powerDown,
  output logic selfRefresh,
  output logic otfEnabled,
  output logic burstActive,
  output logic burstWrite,
  output logic [dcd_pkg::ADDR_W-1:0] burstRow,
  output logic [dcd_pkg::ADDR_W-1:0] burstStartColumn,
  output logic beatValid,
  output logic [dcd_pkg::ADDR_W-1:0] beatColumn,
  output logic [1:0] beatLaneEn,
  output logic [dcd_pkg::DQ_W-1:0] beatData,
  output logic coreWordValid,
  output logic [dcd_pkg::CORE_W-1:0] coreWord,
  output logic [dcd_pkg::BYTES_W-1:0] coreByteEn
);
  import dcd_pkg::*;

  logic [SYNC_W-1:0] pinsS;
  logic ckS, ckeS, csNS, rasNS, casNS, weNS, udmS, ldmS;
  logic [BANK_W-1:0] baS;
  logic [ADDR_W-1:0] addrS;
  logic [DQ_W-1:0] dqS;

  dcd_pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk(clk),
    .rst(rst),
    .asyncIn({ckPin, ckeIn, csN, rasN, casN, weN, bankSelect, rowColumnLines, upperByteMask, lowerByteMask, dqIn}),
    .syncOut(pinsS)
  );
  assign {ckS, ckeS, csNS, rasNS, casNS, weNS, baS, addrS, udmS, ldmS, dqS} = pinsS;

  logic ckLast_q, ckLast_d, ckePrev_q, ckePrev_d;
  logic cmdValid_q, cmdValid_d, cmdAp_q, cmdAp_d, cmdChop_q, cmdChop_d, zqLong_q, zqLong_d;
  dcd_cmd_e cmdCode_q, cmdCode_d, decCode;
  logic [BANK_W-1:0] cmdBank_q, cmdBank_d;
  logic [ADDR_W-1:0] cmdAddr_q, cmdAddr_d;
  logic [NUM_BANKS-1:0] bankActive_q, bankActive_d;
  logic [ADDR_W-1:0] openRow_q [NUM_BANKS];
  logic [ADDR_W-1:0] openRow_d [NUM_BANKS];
  logic powerDown_q, powerDown_d, selfRefresh_q, selfRefresh_d;
  logic otf_q, otf_d, fixChop_q, fixChop_d, interleave_q, interleave_d;
  logic ckRise, linkEdge, isNop, allIdle, apClose, rwCmd;
  logic burstActive_q, burstActive_d, burstWrite_q, burstWrite_d, burstChop_q, burstChop_d;
  logic burstAp_q, burstAp_d, burstIlv_q, burstIlv_d;
  logic [BANK_W-1:0] burstBank_q, burstBank_d;
  logic [ADDR_W-1:0] burstRow_q, burstRow_d, burstStart_q, burstStart_d, beatCol_q, beatCol_d;
  logic [BEAT_W-1:0] beatCnt_q, beatCnt_d, lastBeat, ord;
  logic beatValid_q, beatValid_d, coreValid_q, coreValid_d;
  logic [1:0] laneEn_q, laneEn_d;
  logic [DQ_W-1:0] beatData_q, beatData_d;
  logic [CORE_W-1:0] coreWord_q, coreWord_d;
  logic [BYTES_W-1:0] coreEn_q, coreEn_d;

  // Both edges carry data beats; only the rising edge carries commands
  assign ckRise = ckS & ~ckLast_q;
  assign linkEdge = ckS ^ ckLast_q;
  assign isNop = ~csNS & ({rasNS, casNS, weNS} == ENC_NOP);
  assign allIdle = (bankActive_q == '0);
  assign rwCmd = (decCode == CMD_RD) || (decCode == CMD_WR);

  always_comb
  begin
    ckLast_d = ckS;
    ckePrev_d = ckePrev_q;
    cmdValid_d = 1'b0;
    cmdCode_d = cmdCode_q;
    cmdBank_d = cmdBank_q;
    cmdAddr_d = cmdAddr_q;
    cmdAp_d = cmdAp_q;
    cmdChop_d = cmdChop_q;
    zqLong_d = zqLong_q;
    bankActive_d = bankActive_q;
    openRow_d = openRow_q;
    powerDown_d = powerDown_q;
    selfRefresh_d = selfRefresh_q;
    otf_d = otf_q;
    fixChop_d = fixChop_q;
    interleave_d = interleave_q;
    decCode = CMD_NONE;
    if (apClose)
      bankActive_d[burstBank_q] = 1'b0;
    if (ckRise)
    begin
      ckePrev_d = ckeS;
      if (powerDown_q || selfRefresh_q)
      begin
        // Everything but a clean exit is ignored while asleep
        if (!ckePrev_q && ckeS && (csNS || isNop))
          decCode = selfRefresh_q ? CMD_SRX : CMD_PDX;
      end
      else if (ckePrev_q && !ckeS)
      begin
        if ((csNS || isNop) && allIdle)
          decCode = CMD_PDE;
        else if (!csNS && ({rasNS, casNS, weNS} == ENC_REF) && allIdle)
          decCode = CMD_SRE;
      end
      else if (ckePrev_q)
      begin
        // Gate low in the previous cycle outside sleep means still initialising
        if (csNS)
          decCode = CMD_DES;
        else
        begin
          // Commands breaking bank preconditions are dropped
          case ({rasNS, casNS, weNS})
            ENC_ACT: decCode = bankActive_q[baS] ? CMD_NONE : CMD_ACT;
            ENC_PRE: decCode = addrS[AP_BIT] ? CMD_PREA : CMD_PRE;
            ENC_WR: decCode = bankActive_q[baS] ? CMD_WR : CMD_NONE;
            ENC_RD: decCode = bankActive_q[baS] ? CMD_RD : CMD_NONE;
            ENC_MRS: decCode = allIdle ? CMD_MRS : CMD_NONE;
            ENC_REF: decCode = allIdle ? CMD_REF : CMD_NONE;
            ENC_ZQ: decCode = !allIdle ? CMD_NONE : (addrS[AP_BIT] ? CMD_ZQCL : CMD_ZQCS);
            ENC_NOP: decCode = CMD_NOP;
            default: decCode = CMD_NONE;
          endcase
        end
      end
    end
    if (decCode != CMD_NONE)
    begin
      cmdValid_d = 1'b1;
      cmdCode_d = decCode;
      cmdBank_d = baS;
      cmdAddr_d = addrS;
      cmdAp_d = addrS[AP_BIT];
      cmdChop_d = otf_q ? !addrS[CHOP_BIT] : fixChop_q;
    end
    case (decCode)
      CMD_ACT:
      begin
        bankActive_d[baS] = 1'b1;
        openRow_d[baS] = addrS;
      end
      CMD_PRE: bankActive_d[baS] = 1'b0;
      CMD_PREA: bankActive_d = '0;
      CMD_MRS:
      begin
        if (baS == MR0_BANK)
        begin
          otf_d = (addrS[1:0] == BL_OTF);
          fixChop_d = (addrS[1:0] == BL_FIXED4);
          interleave_d = addrS[BT_BIT];
        end
      end
      CMD_SRE: selfRefresh_d = 1'b1;
      CMD_PDE: powerDown_d = 1'b1;
      CMD_SRX: selfRefresh_d = 1'b0;
      CMD_PDX: powerDown_d = 1'b0;
      CMD_ZQCL: zqLong_d = 1'b1;
      CMD_ZQCS: zqLong_d = 1'b0;
      default: zqLong_d = zqLong_q;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ckLast_q <= 1'b0;
      ckePrev_q <= 1'b0;
      cmdValid_q <= 1'b0;
      cmdCode_q <= CMD_NONE;
      cmdBank_q <= '0;
      cmdAddr_q <= '0;
      cmdAp_q <= 1'b0;
      cmdChop_q <= 1'b0;
      zqLong_q <= 1'b0;
      bankActive_q <= '0;
      openRow_q <= '{default: '0};
      powerDown_q <= 1'b0;
      selfRefresh_q <= 1'b0;
      otf_q <= 1'b0;
      fixChop_q <= 1'b0;
      interleave_q <= 1'b0;
    end
    else
    begin
      ckLast_q <= ckLast_d;
      ckePrev_q <= ckePrev_d;
      cmdValid_q <= cmdValid_d;
      cmdCode_q <= cmdCode_d;
      cmdBank_q <= cmdBank_d;
      cmdAddr_q <= cmdAddr_d;
      cmdAp_q <= cmdAp_d;
      cmdChop_q <= cmdChop_d;
      zqLong_q <= zqLong_d;
      bankActive_q <= bankActive_d;
      openRow_q <= openRow_d;
      powerDown_q <= powerDown_d;
      selfRefresh_q <= selfRefresh_d;
      otf_q <= otf_d;
      fixChop_q <= fixChop_d;
      interleave_q <= interleave_d;
    end
  end

  assign lastBeat = burstChop_q ? LAST_CHOP : LAST_FULL;
  assign apClose = burstActive_q && linkEdge && (beatCnt_q == lastBeat) && burstAp_q;

  always_comb
  begin
    burstActive_d = burstActive_q;
    burstWrite_d = burstWrite_q;
    burstChop_d = burstChop_q;
    burstAp_d = burstAp_q;
    burstIlv_d = burstIlv_q;
    burstBank_d = burstBank_q;
    burstRow_d = burstRow_q;
    burstStart_d = burstStart_q;
    beatCol_d = beatCol_q;
    beatCnt_d = beatCnt_q;
    beatValid_d = 1'b0;
    laneEn_d = 2'h0;
    beatData_d = beatData_q;
    coreValid_d = 1'b0;
    coreWord_d = coreWord_q;
    coreEn_d = coreEn_q;
    // Chopped bursts wrap inside their half of the eight-column block
    ord = burstIlv_q ? (burstStart_q[2:0] ^ beatCnt_q) : (burstStart_q[2:0] + beatCnt_q);
    if (burstChop_q)
      ord[2] = burstStart_q[2];
    if (burstActive_q && linkEdge)
    begin
      beatValid_d = 1'b1;
      beatCol_d = {burstStart_q[ADDR_W-1:3], ord};
      if (burstWrite_q)
      begin
        laneEn_d = {~udmS, ~ldmS};
        beatData_d = dqS;
        if (!ldmS)
          coreWord_d[{beatCnt_q, 4'h0} +: LANE_W] = dqS[LANE_W-1:0];
        if (!udmS)
          coreWord_d[{beatCnt_q, 4'h8} +: LANE_W] = dqS[DQ_W-1:LANE_W];
        coreEn_d[{beatCnt_q, 1'b0}] = ~ldmS;
        coreEn_d[{beatCnt_q, 1'b1}] = ~udmS;
      end
      beatCnt_d = beatCnt_q + 3'h1;
      if (beatCnt_q == lastBeat)
      begin
        burstActive_d = 1'b0;
        coreValid_d = 1'b1;
      end
    end
    // A new column command restarts the engine; a finishing word still pulses valid but with its byte enables cleared
    if (rwCmd)
    begin
      burstActive_d = 1'b1;
      burstWrite_d = (decCode == CMD_WR);
      burstChop_d = cmdChop_d;
      burstAp_d = addrS[AP_BIT];
      burstIlv_d = interleave_q;
      burstBank_d = baS;
      burstRow_d = openRow_q[baS];
      burstStart_d = addrS;
      beatCnt_d = 3'h0;
      coreEn_d = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      burstActive_q <= 1'b0;
      burstWrite_q <= 1'b0;
      burstChop_q <= 1'b0;
      burstAp_q <= 1'b0;
      burstIlv_q <= 1'b0;
      burstBank_q <= '0;
      burstRow_q <= '0;
      burstStart_q <= '0;
      beatCol_q <= '0;
      beatCnt_q <= '0;
      beatValid_q <= 1'b0;
      laneEn_q <= 2'h0;
      beatData_q <= '0;
      coreValid_q <= 1'b0;
      coreWord_q <= '0;
      coreEn_q <= '0;
    end
    else
    begin
      burstActive_q <= burstActive_d;
      burstWrite_q <= burstWrite_d;
      burstChop_q <= burstChop_d;
      burstAp_q <= burstAp_d;
      burstIlv_q <= burstIlv_d;
      burstBank_q <= burstBank_d;
      burstRow_q <= burstRow_d;
      burstStart_q <= burstStart_d;
      beatCol_q <= beatCol_d;
      beatCnt_q <= beatCnt_d;
      beatValid_q <= beatValid_d;
      laneEn_q <= laneEn_d;
      beatData_q <= beatData_d;
      coreValid_q <= coreValid_d;
      coreWord_q <= coreWord_d;
      coreEn_q <= coreEn_d;
    end
  end

  assign cmdValid = cmdValid_q;
  assign cmdCode = cmdCode_q;
  assign cmdBank = cmdBank_q;
  assign cmdAddr = cmdAddr_q;
  assign cmdAutoPrecharge = cmdAp_q;
  assign cmdChopped = cmdChop_q;
  assign zqLong = zqLong_q;
  assign bankActive = bankActive_q;
  assign powerDown = powerDown_q;
  assign selfRefresh = selfRefresh_q;
  assign otfEnabled = otf_q;
  assign burstActive = burstActive_q;
  assign burstWrite = burstWrite_q;
  assign burstRow = burstRow_q;
  assign burstStartColumn = burstStart_q;
  assign beatValid = beatValid_q;
  assign beatColumn = beatCol_q;
  assign beatLaneEn = laneEn_q;
  assign beatData = beatData_q;
  assign coreWordValid = coreValid_q;
  assign coreWord = coreWord_q;
  assign coreByteEn = coreEn_q;

  property p_act;
    @(posedge clk) disable iff (rst) cmdValid && cmdCode == CMD_ACT |-> bankActive[cmdBank] && openRow_q[cmdBank] == cmdAddr;
  endproperty
  a_act: assert property (p_act) else $error("activate left bank closed");
  property p_pre;
    @(posedge clk) disable iff (rst) cmdValid && cmdCode == CMD_PREA |-> bankActive == '0;
  endproperty
  a_pre: assert property (p_pre) else $error("precharge all left a bank open");
  property p_wr;
    @(posedge clk) disable iff (rst) cmdValid && cmdCode == CMD_WR |-> burstActive && burstWrite && burstStartColumn == cmdAddr;
  endproperty
  a_wr: assert property (p_wr) else $error("write did not start a write burst");
  property p_rd;
    @(posedge clk) disable iff (rst) cmdValid && cmdCode == CMD_RD |-> burstActive && !burstWrite;
  endproperty
  a_rd: assert property (p_rd) else $error("read did not start a read burst");
  property p_chop;
    @(posedge clk) disable iff (rst) cmdValid && otfEnabled && (cmdCode == CMD_RD || cmdCode == CMD_WR) |-> cmdChopped == !cmdAddr[CHOP_BIT];
  endproperty
  a_chop: assert property (p_chop) else $error("burst chop mismatch");
  property p_mrs;
    @(posedge clk) disable iff (rst) cmdValid && cmdCode == CMD_MRS |-> $past(bankActive) == '0;
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode set with open bank");
  property p_pde;
    @(posedge clk) disable iff (rst) cmdValid && cmdCode == CMD_PDE |-> powerDown && !$past(powerDown);
  endproperty
  a_pde: assert property (p_pde) else $error("power-down not entered");
  property p_sre;
    @(posedge clk) disable iff (rst) cmdValid && cmdCode == CMD_SRE |-> selfRefresh && bankActive == '0;
  endproperty
  a_sre: assert property (p_sre) else $error("self-refresh not entered");
  property p_exit;
    @(posedge clk) disable iff (rst) cmdValid && (cmdCode == CMD_PDX || cmdCode == CMD_SRX) |-> !powerDown && !selfRefresh;
  endproperty
  a_exit: assert property (p_exit) else $error("low power not exited");
  property p_mask;
    @(posedge clk) disable iff (rst) beatValid && burstWrite |-> beatLaneEn == ~$past({udmS, ldmS});
  endproperty
  a_mask: assert property (p_mask) else $error("lane enable ignores mask");
  property p_burst;
    @(posedge clk) disable iff (rst) $rose(burstActive) |-> ##[1:70] coreWordValid;
  endproperty
  a_burst: assert property (p_burst) else $error("burst never completed");
  property p_des;
    // A deselect on the closing edge of an auto-close burst sees that bank shut
    @(posedge clk) disable iff (rst) cmdValid && cmdCode == CMD_DES |->
      ($stable(bankActive) || $past(apClose)) && $stable(powerDown) && $stable(selfRefresh);
  endproperty
  a_des: assert property (p_des) else $error("deselect changed state");
  property p_zq;
    @(posedge clk) disable iff (rst) cmdValid && cmdCode == CMD_ZQCL |-> zqLong && cmdAutoPrecharge;
  endproperty
  a_zq: assert property (p_zq) else $error("long calibration not flagged");
endmodule
`default_nettype wire

//--- tb/dcd_ctrl_model.sv
// Controller-side pin model: command frames, clock gate, write data and byte masks
`timescale 1ns/100ps
`default_nettype none
module dcd_ctrl_model (
  input wire logic clk,
  output logic ckPin,
  output logic ckeIn,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic [2:0] bankSelect,
  output logic [13:0] rowColumnLines,
  output logic lowerByteMask,
  output logic upperByteMask,
  output logic [15:0] dqIn
);
  initial
  begin
    {ckPin, ckeIn, csN, rasN, casN, weN} = 6'h0F;
    {bankSelect, rowColumnLines} = 17'h00000;
    {lowerByteMask, upperByteMask, dqIn} = 18'h00000;
  end
  // Lines settle four clk cycles before the rise; the gate stays driven between frames
  task automatic issue(input logic cke, input logic [3:0] enc, input logic [2:0] ba, input logic [13:0] a);
    repeat (2) @(posedge clk);
    ckeIn <= cke;
    {csN, rasN, casN, weN} <= enc;
    bankSelect <= ba;
    rowColumnLines <= a;
    repeat (4) @(posedge clk);
    ckPin <= 1'b1;
  endtask
  // Clock stops low after a frame; released lines flip so stale values never look valid
  task automatic idle();
    repeat (4) @(posedge clk);
    ckPin <= 1'b0;
    bankSelect <= ~bankSelect;
    rowColumnLines <= ~rowColumnLines;
    dqIn <= ~dqIn;
  endtask
  // Data and masks change mid-phase so each is settled across its sampling edge
  task automatic beats(input int n, input logic [127:0] w, input logic [15:0] m);
    for (int k = 0; k < n; k++)
    begin
      repeat (2) @(posedge clk);
      csN <= 1'b1;
      dqIn <= w[16*k +: 16];
      {upperByteMask, lowerByteMask} <= m[2*k +: 2];
      repeat (2) @(posedge clk);
      ckPin <= ~ckPin;
    end
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the DDR3 command decoder driven by the controller model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dcd_pkg::*;
  logic clk;
  logic rst;
  wire logic ckPin, ckeIn, csN, rasN, casN, weN, lowerByteMask, upperByteMask;
  wire logic [2:0] bankSelect;
  wire logic [13:0] rowColumnLines;
  wire logic [15:0] dqIn;
  logic cmdValid, cmdAutoPrecharge, cmdChopped, zqLong, powerDown, selfRefresh;
  logic otfEnabled, burstActive, burstWrite, beatValid, coreWordValid;
  dcd_cmd_e cmdCode;
  logic [2:0] cmdBank;
  logic [13:0] cmdAddr, burstRow, burstStartColumn, beatColumn;
  logic [1:0] beatLaneEn;
  logic [15:0] beatData, coreByteEn;
  logic [7:0] bankActive;
  logic [127:0] coreWord;
  int cmdCnt = 0;
  int errorCnt = 0;
  int samplesChecked = 0;
  int wordCnt = 0;
  logic ilvMode = 1'b0;
  logic [13:0] colQ[$];
  logic [1:0] laneQ[$];
  logic [15:0] dataQ[$];

  dcd_ctrl_model dcd_ctrl_model_inst (.clk(clk), .ckPin(ckPin), .ckeIn(ckeIn), .csN(csN), .rasN(rasN),
    .casN(casN), .weN(weN), .bankSelect(bankSelect), .rowColumnLines(rowColumnLines),
    .lowerByteMask(lowerByteMask), .upperByteMask(upperByteMask), .dqIn(dqIn));
  dcd_command_decoder dcd_command_decoder_inst (.clk(clk), .rst(rst), .ckPin(ckPin), .ckeIn(ckeIn),
    .csN(csN), .rasN(rasN), .casN(casN), .weN(weN), .bankSelect(bankSelect), .rowColumnLines(rowColumnLines),
    .lowerByteMask(lowerByteMask), .upperByteMask(upperByteMask), .dqIn(dqIn), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .cmdBank(cmdBank), .cmdAddr(cmdAddr), .cmdAutoPrecharge(cmdAutoPrecharge),
    .cmdChopped(cmdChopped), .zqLong(zqLong), .bankActive(bankActive), .powerDown(powerDown),
    .selfRefresh(selfRefresh), .otfEnabled(otfEnabled), .burstActive(burstActive), .burstWrite(burstWrite),
    .burstRow(burstRow), .burstStartColumn(burstStartColumn), .beatValid(beatValid), .beatColumn(beatColumn),
    .beatLaneEn(beatLaneEn), .beatData(beatData), .coreWordValid(coreWordValid), .coreWord(coreWord),
    .coreByteEn(coreByteEn));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Pulses are one cycle wide, so count and log them as they pass
  always @(posedge clk)
  begin
    if (cmdValid === 1'b1)
      cmdCnt++;
    if (beatValid === 1'b1)
    begin
      colQ.push_back(beatColumn);
      laneQ.push_back(beatLaneEn);
      dataQ.push_back(beatData);
    end
    if (coreWordValid === 1'b1)
      wordCnt++;
  end

  task automatic chkVal(input logic [127:0] got, input logic [127:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkCode(input dcd_cmd_e got, input dcd_cmd_e exp);
    samplesChecked++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrapUp();
    $display("checks=%0d errors=%0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One frame; CMD_NONE means the decoder must stay silent
  task automatic cmd(input logic cke, input logic [3:0] enc, input logic [2:0] ba, input logic [13:0] a,
    input dcd_cmd_e exp);
    int n0;
    n0 = cmdCnt;
    dcd_ctrl_model_inst.issue(cke, enc, ba, a);
    tick(6);
    chkVal(128'(cmdCnt - n0), (exp == CMD_NONE) ? 128'h0 : 128'h1); // Pulse or silence
    if (exp != CMD_NONE)
      chkCode(cmdCode, exp); // Decoded kind
    dcd_ctrl_model_inst.idle();
  endtask

  task automatic burst(input logic [3:0] enc, input logic [2:0] ba, input logic [13:0] a, input logic [13:0] row,
    input int n, input logic [127:0] w, input logic [15:0] m, input dcd_cmd_e exp);
    int n0;
    int w0;
    logic [2:0] c;
    logic [127:0] e;
    n0 = cmdCnt;
    w0 = wordCnt;
    colQ.delete();
    laneQ.delete();
    dataQ.delete();
    dcd_ctrl_model_inst.issue(1'b1, enc, ba, a);
    tick(6);
    chkVal(128'(cmdCnt - n0), 128'h1); // One command
    chkVal(burstWrite, exp == CMD_WR); // Direction
    chkCode(cmdCode, exp); // Decoded kind
    chkVal(burstRow, row); // Open row
    chkVal(burstStartColumn[9:0], a[9:0]); // Start column
    chkVal(cmdChopped, n == 4); // Chop line
    chkVal(cmdAutoPrecharge, a[AP_BIT]); // Auto-close
    dcd_ctrl_model_inst.beats(n, w, m);
    dcd_ctrl_model_inst.idle();
    tick(6);
    chkVal(colQ.size(), n); // Beat count
    chkVal(128'(wordCnt - w0), 128'h1); // One core word per burst
    for (int k = 0; k < n; k++)
    begin
      c = (n == 4) ? {a[2], a[1:0] + 2'(k)} : a[2:0] + 3'(k);
      if (ilvMode)
        c = a[2:0] ^ 3'(k);
      chkVal(colQ[k][2:0], c); // Column order
      chkVal(laneQ[k], (exp == CMD_WR) ? 2'(~m[2*k +: 2]) : 2'h0); // Lane masks
      if (exp == CMD_WR)
        chkVal(dataQ[k], w[16*k +: 16]); // Beat data
    end
    for (int j = 0; j < 16; j++)
      e[8*j +: 8] = m[j] ? 8'h00 : w[8*j +: 8];
    if (exp == CMD_WR)
    begin
      // Masked bytes keep the zeros left by reset; this is the only write of the run
      chkVal(coreWord, e); // Core word
      chkVal(coreByteEn, 16'(~m)); // Byte enables
    end
    chkVal(burstActive, 1'b0); // Burst over
  endtask

  task automatic test_wake();
    cmd(1'b1, 4'h7, 3'h0, 14'h0000, CMD_NONE); // Gate first seen high
    cmd(1'b1, 4'h7, 3'h0, 14'h0000, CMD_NOP); // Plain no-op
    cmd(1'b1, 4'h8, 3'h7, 14'h3FFF, CMD_DES); // Deselect hides a mode set
    chkVal({bankActive, otfEnabled}, 9'h000); // Nothing changed
  endtask
  task automatic test_mode_set();
    cmd(1'b1, {1'b0, ENC_MRS}, MR0_BANK, 14'h0001, CMD_MRS); // Mode set
    chkVal(otfEnabled, 1'b1); // Chop on the fly
  endtask
  task automatic test_open();
    cmd(1'b1, {1'b0, ENC_ACT}, 3'h3, 14'h1ABC, CMD_ACT); // Open bank 3
    chkVal({cmdBank, cmdAddr}, {3'h3, 14'h1ABC}); // Bank and row
    cmd(1'b1, {1'b0, ENC_ACT}, 3'h5, 14'h0123, CMD_ACT); // Open bank 5
    chkVal(bankActive, 8'h28); // Two open banks
    cmd(1'b1, {1'b0, ENC_ACT}, 3'h3, 14'h0777, CMD_NONE); // Already open
    cmd(1'b1, {1'b0, ENC_MRS}, MR0_BANK, 14'h0000, CMD_NONE); // Banks busy
    cmd(1'b1, {1'b0, ENC_REF}, 3'h0, 14'h0000, CMD_NONE); // Banks busy
    chkVal(otfEnabled, 1'b1); // Mode kept
  endtask
  task automatic test_write();
    burst({1'b0, ENC_WR}, 3'h3, 14'h1005, 14'h1ABC, 8, 128'hF00D_1234_5678_9ABC_DEF0_0FED_CBA9_8765,
      16'h9C21, CMD_WR); // Full write
    chkVal(bankActive, 8'h28); // No auto-close
  endtask
  task automatic test_read();
    burst({1'b0, ENC_RD}, 3'h5, 14'h0406, 14'h0123, 4, 128'h0, 16'h0000, CMD_RD); // Chopped read
    chkVal(bankActive, 8'h08); // Auto-close at end
    cmd(1'b1, {1'b0, ENC_RD}, 3'h5, 14'h0000, CMD_NONE); // Closed bank
  endtask
  task automatic test_close();
    cmd(1'b1, {1'b0, ENC_PRE}, 3'h3, 14'h0000, CMD_PRE); // Single close
    chkVal(bankActive, 8'h00); // All idle
    cmd(1'b1, {1'b0, ENC_ACT}, 3'h1, 14'h0042, CMD_ACT); // Open bank 1
    cmd(1'b1, {1'b0, ENC_ACT}, 3'h6, 14'h0099, CMD_ACT); // Open bank 6
    chkVal(bankActive, 8'h42); // Independent banks
    cmd(1'b1, {1'b0, ENC_PRE}, 3'h0, 14'h0400, CMD_PREA); // Close all
    chkVal(bankActive, 8'h00); // All idle
  endtask
  task automatic test_sleep();
    cmd(1'b1, {1'b0, ENC_REF}, 3'h0, 14'h0000, CMD_REF); // Refresh
    cmd(1'b0, {1'b0, ENC_REF}, 3'h0, 14'h0000, CMD_SRE); // Gate falls
    chkVal(selfRefresh, 1'b1); // Asleep
    cmd(1'b0, {1'b0, ENC_ACT}, 3'h2, 14'h0001, CMD_NONE); // Ignored asleep
    cmd(1'b1, {1'b0, ENC_NOP}, 3'h0, 14'h0000, CMD_SRX); // Gate rises
    chkVal({selfRefresh, bankActive}, 9'h000); // Awake, idle
  endtask
  task automatic test_pd();
    cmd(1'b0, {1'b0, ENC_NOP}, 3'h0, 14'h0000, CMD_PDE); // Gate falls
    chkVal(powerDown, 1'b1); // Powered down
    cmd(1'b1, 4'hF, 3'h0, 14'h0000, CMD_PDX); // Exit on deselect
    chkVal(powerDown, 1'b0); // Awake
  endtask
  task automatic test_zq();
    cmd(1'b1, {1'b0, ENC_ZQ}, 3'h0, 14'h0400, CMD_ZQCL); // Long
    chkVal(zqLong, 1'b1); // Long kept
    cmd(1'b1, {1'b0, ENC_ZQ}, 3'h0, 14'h0000, CMD_ZQCS); // Short
    chkVal(zqLong, 1'b0); // Short kept
  endtask
  task automatic test_ilv();
    cmd(1'b1, {1'b0, ENC_MRS}, MR0_BANK, 14'h000A, CMD_MRS); // Fixed chop, interleaved
    chkVal(otfEnabled, 1'b0); // Chop line now ignored
    ilvMode = 1'b1;
    cmd(1'b1, {1'b0, ENC_ACT}, 3'h2, 14'h0055, CMD_ACT); // Open bank 2
    burst({1'b0, ENC_RD}, 3'h2, 14'h1403, 14'h0055, 4, 128'h0, 16'h0000, CMD_RD); // Fixed chop read
    chkVal(bankActive, 8'h00); // Auto-close at end
  endtask

  initial
  begin
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    test_wake();
    test_mode_set();
    test_open();
    test_write();
    test_read();
    test_close();
    test_ilv();
    test_sleep();
    test_pd();
    test_zq();
    wrapUp();
  end
  // Whole run needs about 520 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    wrapUp();
  end
endmodule
`default_nettype wire
